// ---- ffee_ctl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// write-side controller and free-running read clock beside the fifo
module ffee_ctl_model #(
  parameter int WDIV = 3, // system cycles per write clock
  parameter int RDIV = 2  // system cycles per read clock
) (
  input  wire logic        clk_i,     // system clock
  input  wire logic        rst_n_i,   // reset, active low
  output logic             wclk_en_o, // write clock edge
  output logic             rclk_en_o, // read clock edge
  output logic             wen_n_o,   // write request, active low
  output logic      [35:0] wdata_o    // write word
);
  int          wc;   // write clock phase
  int          rc;   // read clock phase
  logic [35:0] q[$]; // words waiting to be written
  // quiet outputs before the first edge
  initial begin
    wclk_en_o = 1'b0;
    rclk_en_o = 1'b0;
    wen_n_o   = 1'b1;
    wdata_o   = 36'h0;
  end
  // pulses run freely; one word offered per write clock
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wc        <= 0;
      rc        <= 0;
      wclk_en_o <= 1'b0;
      rclk_en_o <= 1'b0;
      wen_n_o   <= 1'b1;
      q.delete();
    end else begin
      wc        <= (wc == WDIV - 1) ? 0 : wc + 1;
      rc        <= (rc == RDIV - 1) ? 0 : rc + 1;
      wclk_en_o <= (wc == WDIV - 1);
      rclk_en_o <= (rc == RDIV - 1);
      if (wc == WDIV - 1 && q.size() != 0) begin
        // request held up to the sampling write edge
        wen_n_o <= 1'b0;
        wdata_o <= q.pop_front();
      end else if (wclk_en_o) begin
        // hold over: drop request, scramble data
        wen_n_o <= 1'b1;
        wdata_o <= ~wdata_o;
      end
    end
  end
endmodule : ffee_ctl_model
`default_nettype wire

// ---- ffee_defs.svh ----
`ifndef FFEE_DEFS_SVH
`define FFEE_DEFS_SVH

// array geometry
`define FFEE_PTR_W        10
`define FFEE_CNT_W        11
`define FFEE_DATA_W       36
`define FFEE_DEPTH_STD    11'h400
`define FFEE_DEPTH_FALL_THROUGH_MODE   11'h401

// apb register byte offsets
`define FFEE_AW           8
`define FFEE_OFS_AE       8'h00
`define FFEE_OFS_AF       8'h04
`define FFEE_OFS_STATUS   8'h08
`define FFEE_OFS_LEVEL    8'h0C

// reset values of the offset registers
`define FFEE_AE_RST       11'h008
`define FFEE_AF_RST       11'h008

// status register bit positions
`define FFEE_ST_FALL_THROUGH_MODE      0
`define FFEE_ST_SYNCFLG   1
`define FFEE_ST_ASYNCRD   2
`define FFEE_ST_EMPTY_N   3
`define FFEE_ST_FULL_N    4
`define FFEE_ST_OR_N      5
`define FFEE_ST_IR_N      6
`define FFEE_ST_AE_N      7
`define FFEE_ST_AF_N      8

`endif

// ---- ffee_pkg.sv ----
`default_nettype none
package ffee_pkg;
  // read-side timing convention, latched at reset
  typedef enum logic {
    FFEE_STANDARD,
    FFEE_FALL_THROUGH
  } ffee_mode_t;
  // one stored word
  typedef logic [35:0] ffee_word_t;
endpackage : ffee_pkg
`default_nettype wire

// ---- ffee_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ffee_defs.svh"

// Functional notes
// - async mode: almost-full set write, cleared read
// - async mode: almost-empty set read, cleared write
// - timing select low at reset picks async
// - timing select high: sync, write-edge almost-full
// - max depth 1024 standard, 1025 fall-through
// - echo enable follows select and enable, high empty
// - echo enable generated on read clock, or on falling read enable in unclocked read
// - data bus driven only select and oe low
// - fall-through word loads unread, ready low, echo pulse
// - echo high when no new word loaded
// - read after last word: ready high, echo high
// - unclocked read only in standard mode
// - flag edges may skew one cycle between devices
// - chain ripples first word; read clock free-running
// - output ready low acts as next write enable
// - chain latency 4 transfer plus 3 read clocks
// - ripple delay only for first word
// - freed space bubbles back via input ready
module ffee_top (
  input  wire logic        sys_clk_i,             // system clock, 125 MHz
  input  wire logic        rst_n_i,               // master reset, active low
  input  wire logic        fall_through_mode_i,   // mode strap, sampled in reset
  input  wire logic        flag_timing_select_i,  // almost-flag timing strap
  input  wire logic        async_read_i,          // unclocked read strap
  input  wire logic        wclk_en_i,             // write clock edge enable
  input  wire logic        write_enable_n_i,      // write request
  input  wire logic [35:0] write_data_i,          // write data
  input  wire logic        rclk_en_i,             // read clock edge enable
  input  wire logic        read_select_n_i,       // read select
  input  wire logic        read_enable_n_i,       // read enable
  input  wire logic        output_enable_n_i,     // output enable
  output logic      [35:0] output_data_bus_o,     // output register
  output logic             output_data_oe_n_o,    // low while bus driven
  output logic             echo_read_enable_n_o,  // echo read enable
  output logic             empty_n_o,             // standard empty flag
  output logic             full_n_o,              // standard full flag
  output logic             output_ready_n_o,      // fall-through output ready
  output logic             input_ready_n_o,       // fall-through input ready
  output logic             almost_empty_n_o,      // almost empty flag
  output logic             almost_full_n_o,       // almost full flag
  input  wire logic        psel_i,                // apb select
  input  wire logic        penable_i,             // apb enable
  input  wire logic        pwrite_i,              // apb direction
  input  wire logic [7:0]  paddr_i,               // apb byte address
  input  wire logic [31:0] pwdata_i,              // apb write data
  output logic      [31:0] prdata_o,              // apb read data
  output logic             pready_o,              // apb ready
  output logic             pslverr_o              // apb error
);

  // depth chosen by mode, widened for threshold sums
  function automatic logic [11:0] max_depth(input ffee_pkg::ffee_mode_t m);
    max_depth = (m == ffee_pkg::FFEE_FALL_THROUGH) ? {1'b0, `FFEE_DEPTH_FALL_THROUGH_MODE}
                                                   : {1'b0, `FFEE_DEPTH_STD};
  endfunction : max_depth

  logic [1:0]                    rst_q;       // reset release pair
  logic                          rst_sync_n;  // released reset
  ffee_pkg::ffee_mode_t          mode_q;      // latched read mode
  logic                          sync_flg_q;  // latched flag timing
  logic                          async_rd_q;  // latched unclocked read
  ffee_pkg::ffee_word_t          mem_q [1024];
  logic [`FFEE_PTR_W-1:0]        wptr_q;      // write pointer
  logic [`FFEE_PTR_W-1:0]        rptr_q;      // read pointer
  logic [`FFEE_CNT_W-1:0]        cnt_q;       // words in array
  logic                          ov_q;        // output register valid
  logic [1:0]                    ne_q;        // fall-through arrival pipe
  logic                          ren_q;       // last read enable level
  logic [`FFEE_CNT_W-1:0]        ae_off_q;    // almost-empty offset
  logic [`FFEE_CNT_W-1:0]        af_off_q;    // almost-full offset
  ffee_pkg::ffee_word_t          dout_q;      // output register
  logic                          oe_n_q;      // bus drive, low active
  logic                          echo_q;      // echo read enable
  logic                          ef_q;        // empty_n
  logic                          ff_q;        // full_n
  logic                          or_q;        // output_ready_n
  logic                          ir_q;        // input_ready_n
  logic                          ae_q;        // almost_empty_n
  logic                          af_q;        // almost_full_n
  logic [31:0]                   prdata_q;    // apb read data
  logic                          pready_q;    // apb ready
  logic                          pslverr_q;   // apb error

  // reset release through two flops
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) rst_q <= 2'h0;
    else          rst_q <= {rst_q[0], 1'h1};
  end
  assign rst_sync_n = rst_q[1];

  // straps follow their pins while reset holds, frozen after
  always_ff @(posedge sys_clk_i) begin
    if (!rst_sync_n) begin
      mode_q     <= fall_through_mode_i ? ffee_pkg::FFEE_FALL_THROUGH
                                        : ffee_pkg::FFEE_STANDARD;
      sync_flg_q <= flag_timing_select_i;
      async_rd_q <= async_read_i & ~fall_through_mode_i;
    end
  end

  // decode of the data path
  wire fall_through_mode     = (mode_q == ffee_pkg::FFEE_FALL_THROUGH);
  wire mem_ne   = (cnt_q != 11'h000);
  wire mem_full = (cnt_q == `FFEE_DEPTH_STD);
  wire rd_req   = ~read_select_n_i & ~read_enable_n_i;
  wire wr_fire  = wclk_en_i & ~write_enable_n_i & ~mem_full;
  // unclocked read fires on the falling enable in standard mode
  wire rd_tick  = async_rd_q ? (ren_q & ~read_enable_n_i) : rclk_en_i;
  // fall-through: first word waits the arrival pipe, then moves unread
  wire ft_load  = rclk_en_i & mem_ne & ((~ov_q & ne_q[1]) | (ov_q & rd_req));
  wire std_load = rd_tick & rd_req & mem_ne;
  wire load     = fall_through_mode ? ft_load : std_load;
  // enabled read with nothing behind the output register
  wire drop     = fall_through_mode & rclk_en_i & rd_req & ov_q & ~mem_ne;
  wire echo_tk  = fall_through_mode ? rclk_en_i : rd_tick;

  wire [`FFEE_CNT_W-1:0] cnt_d = cnt_q + {10'h000, wr_fire} - {10'h000, load};
  wire                   ov_d  = fall_through_mode & (load | (ov_q & ~drop));
  wire [`FFEE_CNT_W-1:0] tot_d = cnt_d + {10'h000, ov_d};
  wire [11:0]            mx    = max_depth(mode_q);
  wire af_cond = ({1'b0, tot_d} + {1'b0, af_off_q}) >= mx;
  wire ae_cond = (tot_d <= ae_off_q);

  // array write port
  always_ff @(posedge sys_clk_i) begin
    if (wr_fire) mem_q[wptr_q] <= write_data_i;
  end

  // pointers, count and output register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wptr_q <= 10'h000;
      rptr_q <= 10'h000;
      cnt_q  <= 11'h000;
      ov_q   <= 1'h0;
      dout_q <= 36'h0;
    end else if (!rst_sync_n) begin
      wptr_q <= 10'h000;
      rptr_q <= 10'h000;
      cnt_q  <= 11'h000;
      ov_q   <= 1'h0;
    end else begin
      if (wr_fire) wptr_q <= wptr_q + 10'h001;
      if (load) begin
        rptr_q <= rptr_q + 10'h001;
        dout_q <= mem_q[rptr_q];
      end
      cnt_q <= cnt_d;
      ov_q  <= ov_d;
    end
  end

  // arrival pipe on read edges gives the 3-read-clock fall-through
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)             ne_q <= 2'h0;
    else if (!rst_sync_n)     ne_q <= 2'h0;
    else if (rclk_en_i)       ne_q <= {ne_q[0], mem_ne};
  end

  // previous enable level for the unclocked read edge
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) ren_q <= 1'h1;
    else          ren_q <= read_enable_n_i;
  end

  // echo: low only on a read edge that loads a new word
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)         echo_q <= 1'h1;
    else if (!rst_sync_n) echo_q <= 1'h1;
    else if (echo_tk)     echo_q <= ~load;
  end

  // bus drive: select and output enable both low
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) oe_n_q <= 1'h1;
    else          oe_n_q <= read_select_n_i | output_enable_n_i;
  end

  // status flags; ready flag edges may skew a cycle vs. peers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ef_q <= 1'h0;
      ff_q <= 1'h1;
      or_q <= 1'h1;
      ir_q <= 1'h0;
    end else if (!rst_sync_n) begin
      ef_q <= 1'h0;
      ff_q <= 1'h1;
      or_q <= 1'h1;
      ir_q <= 1'h0;
    end else begin
      ef_q <= (cnt_d != 11'h000);
      ff_q <= (cnt_d != `FFEE_DEPTH_STD);
      or_q <= ~ov_d;
      ir_q <= ({1'b0, tot_d} == mx);
    end
  end

  // almost-full: async sets on write edge and clears on read edge
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)                 af_q <= 1'h1;
    else if (!rst_sync_n)         af_q <= 1'h1;
    else if (sync_flg_q) begin
      if (wclk_en_i)              af_q <= ~af_cond;
    end else if (wclk_en_i & af_cond) af_q <= 1'h0;
    else if (rclk_en_i & ~af_cond)    af_q <= 1'h1;
  end

  // almost-empty: async sets on read edge and clears on write edge
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)                 ae_q <= 1'h0;
    else if (!rst_sync_n)         ae_q <= 1'h0;
    else if (sync_flg_q) begin
      if (rclk_en_i)              ae_q <= ~ae_cond;
    end else if (rclk_en_i & ae_cond) ae_q <= 1'h0;
    else if (wclk_en_i & ~ae_cond)    ae_q <= 1'h1;
  end

  // apb decode
  wire       setup  = psel_i & ~penable_i;
  wire       hit_ae = (paddr_i == `FFEE_OFS_AE);
  wire       hit_af = (paddr_i == `FFEE_OFS_AF);
  wire       hit_st = (paddr_i == `FFEE_OFS_STATUS);
  wire       hit_lv = (paddr_i == `FFEE_OFS_LEVEL);
  wire       mapped = hit_ae | hit_af | hit_st | hit_lv;
  wire       wr_acc = psel_i & penable_i & pwrite_i & pready_q;
  wire [8:0] status = {af_q, ae_q, ir_q, or_q, ff_q, ef_q,
                       async_rd_q, sync_flg_q, fall_through_mode};
  wire [31:0] rd_mux = hit_ae ? {21'h0, ae_off_q} :
                       hit_af ? {21'h0, af_off_q} :
                       hit_st ? {23'h0, status}   :
                       hit_lv ? {21'h0, cnt_q + {10'h000, ov_q}} : 32'h0;

  // apb answer registered in setup, valid through the access cycle
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_q  <= 32'h0;
      pready_q  <= 1'h0;
      pslverr_q <= 1'h0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup & ~pwrite_i) prdata_q <= rd_mux;
    end
  end

  // offset registers steer the almost flags
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ae_off_q <= `FFEE_AE_RST;
      af_off_q <= `FFEE_AF_RST;
    end else begin
      if (wr_acc & hit_ae) ae_off_q <= pwdata_i[10:0];
      if (wr_acc & hit_af) af_off_q <= pwdata_i[10:0];
    end
  end

  // outputs straight from flops
  assign output_data_bus_o    = dout_q;
  assign output_data_oe_n_o   = oe_n_q;
  assign echo_read_enable_n_o = echo_q;
  assign empty_n_o            = ef_q;
  assign full_n_o             = ff_q;
  assign output_ready_n_o     = or_q;
  assign input_ready_n_o      = ir_q;
  assign almost_empty_n_o     = ae_q;
  assign almost_full_n_o      = af_q;
  assign prdata_o             = prdata_q;
  assign pready_o             = pready_q;
  assign pslverr_o            = pslverr_q;

  // async almost-full only returns high after a read edge
  property p_af_async_rise;
    @(posedge sys_clk_i) disable iff (!rst_sync_n)
    (!sync_flg_q && $rose(af_q)) |-> $past(rclk_en_i);
  endproperty
  a_af_async_rise: assert property (p_af_async_rise)
    else $error("almost_full rose without read edge");

  // async almost-empty only falls on a read edge
  property p_ae_async_fall;
    @(posedge sys_clk_i) disable iff (!rst_sync_n)
    (!sync_flg_q && $fell(ae_q)) |-> $past(rclk_en_i);
  endproperty
  a_ae_async_fall: assert property (p_ae_async_fall)
    else $error("almost_empty fell without read edge");

  // sync almost-full moves on write edges only
  property p_af_sync;
    @(posedge sys_clk_i) disable iff (!rst_sync_n)
    (sync_flg_q && $changed(af_q)) |-> $past(wclk_en_i);
  endproperty
  a_af_sync: assert property (p_af_sync)
    else $error("sync almost_full moved off write edge");

  // empty standard fifo keeps echo high
  property p_echo_empty;
    @(posedge sys_clk_i) disable iff (!rst_sync_n)
    (!fall_through_mode && echo_tk && cnt_q == 11'h000) |=> echo_q;
  endproperty
  a_echo_empty: assert property (p_echo_empty)
    else $error("echo low while empty");

  // no load on a read edge means echo high
  property p_echo_noload;
    @(posedge sys_clk_i) disable iff (!rst_sync_n)
    (echo_tk && !load) |=> echo_q ##1 (echo_q || $past(echo_tk));
  endproperty
  a_echo_noload: assert property (p_echo_noload)
    else $error("echo low without new word");

  // bus floats unless select and oe low
  property p_bus_oe;
    @(posedge sys_clk_i) disable iff (!rst_sync_n)
    (read_select_n_i || output_enable_n_i) |=> oe_n_q;
  endproperty
  a_bus_oe: assert property (p_bus_oe)
    else $error("bus driven while deselected");

  // word falls through: ready and echo low together
  property p_fall_through;
    @(posedge sys_clk_i) disable iff (!rst_sync_n)
    (fall_through_mode && rclk_en_i && !ov_q && mem_ne && ne_q[1]) |=> (!or_q && !echo_q);
  endproperty
  a_fall_through: assert property (p_fall_through)
    else $error("fall-through word not flagged");

  // read past last word raises ready and echo
  property p_last_read;
    @(posedge sys_clk_i) disable iff (!rst_sync_n)
    (fall_through_mode && rclk_en_i && rd_req && ov_q && !mem_ne) |=> (or_q && echo_q);
  endproperty
  a_last_read: assert property (p_last_read)
    else $error("ready stayed low after last word");

  // unclocked read never active in fall-through
  property p_async_std;
    @(posedge sys_clk_i) disable iff (!rst_sync_n)
    fall_through_mode |-> !async_rd_q;
  endproperty
  a_async_std: assert property (p_async_std)
    else $error("unclocked read in fall-through");

  // read from a full fifo frees a place: input ready low
  property p_bubble;
    @(posedge sys_clk_i) disable iff (!rst_sync_n)
    (fall_through_mode && ir_q && rclk_en_i && rd_req && ov_q && mem_ne) |=> !ir_q;
  endproperty
  a_bubble: assert property (p_bubble)
    else $error("input ready not low after read");

endmodule : ffee_top
`default_nettype wire

// ---- fifo_flag_echo_expansion_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ffee_defs.svh"
module fifo_flag_echo_expansion_tb;
  logic        sys_clk_i = 1'b0;            // system clock
  logic        rst_n_i = 1'b0;              // master reset
  logic        fall_through_mode_i = 1'b0;  // mode strap
  logic        flag_timing_select_i = 1'b0; // flag timing strap
  logic        async_read_i = 1'b0;         // unclocked read strap
  logic        read_select_n_i = 1'b1;      // read select
  logic        read_enable_n_i = 1'b1;      // read enable
  logic        output_enable_n_i = 1'b0;    // output enable
  logic        psel_i = 1'b0;               // apb select
  logic        penable_i = 1'b0;            // apb enable
  logic        pwrite_i = 1'b0;             // apb direction
  logic [7:0]  paddr_i = 8'h00;             // apb address
  logic [31:0] pwdata_i = 32'h0;            // apb write data
  logic        wclk_en_i, write_enable_n_i, rclk_en_i; // from the model
  logic [35:0] write_data_i, output_data_bus_o;
  logic [31:0] prdata_o;
  logic        output_data_oe_n_o, echo_read_enable_n_o, empty_n_o, full_n_o;
  logic        output_ready_n_o, input_ready_n_o, almost_empty_n_o, almost_full_n_o;
  logic        pready_o, pslverr_o;
  int          n_errors = 0; // mismatches
  int          n_tests = 0;  // comparisons
  int          cyc = 0;      // cycles run
  logic        echo_prev;    // echo before an edge
  logic [31:0] rd;           // last apb read data
  logic        er;           // last apb error
  logic [35:0] wide_dat;     // second device data
  logic        wide_ef, wide_ff, wide_or, wide_ir; // second device flags
  wire         all_ef = empty_n_o & wide_ef;
  wire         all_ff = full_n_o & wide_ff;
  wire         all_or = output_ready_n_o | wide_or;
  wire         all_ir = input_ready_n_o | wide_ir;

  always #4 sys_clk_i = ~sys_clk_i;

  ffee_top dut_u (
    .sys_clk_i, .rst_n_i, .fall_through_mode_i, .flag_timing_select_i, .async_read_i,
    .wclk_en_i, .write_enable_n_i, .write_data_i, .rclk_en_i, .read_select_n_i,
    .read_enable_n_i, .output_enable_n_i, .output_data_bus_o, .output_data_oe_n_o,
    .echo_read_enable_n_o, .empty_n_o, .full_n_o, .output_ready_n_o, .input_ready_n_o,
    .almost_empty_n_o, .almost_full_n_o, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o
  );
  ffee_ctl_model ctl_u (
    .clk_i(sys_clk_i), .rst_n_i, .wclk_en_o(wclk_en_i), .rclk_en_o(rclk_en_i),
    .wen_n_o(write_enable_n_i), .wdata_o(write_data_i)
  );
  // upper half of a 72-bit pair: same depth, own outputs
  ffee_top wide_u (
    .sys_clk_i, .rst_n_i, .fall_through_mode_i, .flag_timing_select_i, .async_read_i,
    .wclk_en_i, .write_enable_n_i, .write_data_i(~write_data_i), .rclk_en_i,
    .read_select_n_i, .read_enable_n_i, .output_enable_n_i,
    .output_data_bus_o(wide_dat), .output_data_oe_n_o(), .echo_read_enable_n_o(),
    .empty_n_o(wide_ef), .full_n_o(wide_ff), .output_ready_n_o(wide_or),
    .input_ready_n_o(wide_ir), .almost_empty_n_o(), .almost_full_n_o(),
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o(), .pready_o(), .pslverr_o()
  );

  // distinct word per index
  function automatic ffee_pkg::ffee_word_t wd(input int k);
    return 36'hA_5000_0000 ^ (36'h1_0000_1111 * k);
  endfunction : wd

  // verdict and end of run
  task automatic summarize;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  // four-state compare
  task automatic cmp(input logic [35:0] g, input logic [35:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : cmp

  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    @(posedge sys_clk_i);
    while (pready_o !== 1'b1) @(posedge sys_clk_i);
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  // master reset with straps held
  task automatic do_reset(input logic f, input logic s, input logic a);
    @(posedge sys_clk_i);
    rst_n_i              <= 1'b0;
    fall_through_mode_i  <= f;
    flag_timing_select_i <= s;
    async_read_i         <= a;
    read_select_n_i      <= 1'b1;
    read_enable_n_i      <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
  endtask : do_reset

  // wait a read edge, set read controls for the next one
  task automatic rclk(input logic s, input logic e);
    do @(posedge sys_clk_i); while (rclk_en_i !== 1'b1);
    read_select_n_i <= s;
    read_enable_n_i <= e;
    #1;
  endtask : rclk

  // queue words and wait until all are written
  task automatic fill(input int from, input int n);
    for (int i = from; i < from + n; i++) ctl_u.q.push_back(wd(i));
    while (ctl_u.q.size() != 0) @(posedge sys_clk_i);
    repeat (6) @(posedge sys_clk_i);
    #1;
  endtask : fill

  // straps latched at reset, seen in status
  task automatic t_straps;
    for (int i = 0; i < 4; i++) begin
      do_reset(i[0], i[1], 1'b1);
      apb(1'b0, `FFEE_OFS_STATUS, 32'h0);
      cmp(rd[`FFEE_ST_FALL_THROUGH_MODE], i[0], "mode strap");
      cmp(rd[`FFEE_ST_SYNCFLG], i[1], "flag timing strap");
      cmp(rd[`FFEE_ST_ASYNCRD], !i[0], "unclocked read strap");
    end
  endtask : t_straps

  // reset values, read-only and unmapped places
  task automatic t_regs;
    apb(1'b0, `FFEE_OFS_AE, 32'h0);
    cmp(rd, `FFEE_AE_RST, "ae offset reset");
    apb(1'b0, `FFEE_OFS_AF, 32'h0);
    cmp(rd, `FFEE_AF_RST, "af offset reset");
    apb(1'b1, `FFEE_OFS_LEVEL, 32'h0000_00FF);
    cmp(er, 1'b0, "read-only write error");
    apb(1'b0, `FFEE_OFS_LEVEL, 32'h0);
    cmp(rd, 32'h0, "level after ignored write");
    apb(1'b0, 8'h10, 32'h0);
    cmp(er, 1'b1, "unmapped error");
  endtask : t_regs

  // standard mode: flags at depth 1024, echo and bus
  task automatic t_std;
    apb(1'b1, `FFEE_OFS_AF, 32'h0000_03F7);
    fill(0, 9);
    cmp(empty_n_o, 1'b1, "not empty");
    cmp(almost_full_n_o, 1'b0, "af at 1024");
    cmp(almost_empty_n_o, 1'b1, "ae above offset");
    cmp(all_ef, 1'b1, "composite not empty");
    cmp(all_ff, 1'b1, "composite not full");
    rclk(1'b0, 1'b0);
    for (int k = 0; k < 9; k++) begin
      rclk(1'b0, 1'b0);
      cmp(output_data_bus_o, wd(k), "read data");
      cmp(echo_read_enable_n_o, 1'b0, "echo on read");
      cmp(output_data_oe_n_o, 1'b0, "bus driven");
      if (k == 1) begin
        cmp(almost_full_n_o, 1'b1, "af cleared by read");
        cmp(almost_empty_n_o, 1'b0, "ae set by read");
      end
    end
    rclk(1'b0, 1'b1);
    cmp(echo_read_enable_n_o, 1'b1, "echo high when empty");
    cmp(output_data_bus_o, wd(8), "no change on empty read");
    cmp(empty_n_o, 1'b0, "empty after reads");
    @(posedge sys_clk_i);
    output_enable_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1;
    cmp(output_data_oe_n_o, 1'b1, "bus released");
    cmp(echo_read_enable_n_o, 1'b1, "echo idle");
    @(posedge sys_clk_i);
    output_enable_n_i <= 1'b0;
  endtask : t_std

  // fall-through: load without read, depth 1025, last read
  task automatic t_fall_through_mode;
    apb(1'b1, `FFEE_OFS_AF, 32'h0000_03FC);
    ctl_u.q.push_back(wd(0));
    for (int k = 0; k < 12 && output_ready_n_o !== 1'b0; k++) rclk(1'b1, 1'b1);
    cmp(output_ready_n_o, 1'b0, "word fell through");
    cmp(echo_read_enable_n_o, 1'b0, "echo on load");
    cmp(output_data_bus_o, wd(0), "loaded word");
    cmp(output_data_oe_n_o, 1'b1, "bus off unselected");
    cmp(all_or, 1'b0, "composite ready");
    rclk(1'b0, 1'b1);
    cmp(echo_read_enable_n_o, 1'b1, "echo after load");
    fill(1, 3);
    cmp(almost_full_n_o, 1'b1, "no af at 4 words");
    fill(4, 1);
    cmp(almost_full_n_o, 1'b0, "af at 1025");
    rclk(1'b0, 1'b0);
    cmp(output_data_oe_n_o, 1'b0, "word shown before read");
    cmp(output_data_bus_o, wd(0), "word kept");
    for (int k = 1; k < 5; k++) begin
      rclk(1'b0, 1'b0);
      cmp(output_data_bus_o, wd(k), "fall-through read");
      cmp(echo_read_enable_n_o, 1'b0, "echo new word");
      cmp(wide_dat, ~wd(k), "upper half read");
    end
    rclk(1'b1, 1'b1);
    cmp(output_ready_n_o, 1'b1, "ready off after last");
    cmp(echo_read_enable_n_o, 1'b1, "echo off after last");
    fill(5, 1025);
    cmp(input_ready_n_o, 1'b1, "no room at 1025");
    cmp(full_n_o, 1'b0, "array full at 1024");
    cmp(all_ir, 1'b1, "composite no room");
    rclk(1'b0, 1'b1);
    rclk(1'b0, 1'b0);
    rclk(1'b1, 1'b1);
    cmp(output_data_bus_o, wd(6), "read from full");
    cmp(input_ready_n_o, 1'b0, "freed location");
  endtask : t_fall_through_mode

  // standard mode: unclocked reads, synchronous almost flags
  task automatic t_async;
    apb(1'b1, `FFEE_OFS_AF, 32'h0000_03FE);
    fill(0, 2);
    cmp(almost_full_n_o, 1'b0, "sync af at 1024");
    @(posedge sys_clk_i);
    read_select_n_i <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      repeat (2) @(posedge sys_clk_i);
      read_enable_n_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      read_enable_n_i <= 1'b1;
      #1;
      cmp(output_data_bus_o, wd(k), "unclocked read");
      cmp(echo_read_enable_n_o, 1'b0, "echo on unclocked read");
    end
    repeat (4) @(posedge sys_clk_i);
    #1;
    cmp(almost_full_n_o, 1'b1, "sync af off on write edge");
    cmp(all_ef, 1'b0, "composite empty");
  endtask : t_async

  // echo never moves off a read edge
  always @(posedge sys_clk_i) begin
    if (rst_n_i === 1'b1 && rclk_en_i === 1'b0 && async_read_i === 1'b0) begin
      echo_prev = echo_read_enable_n_o;
      #1;
      if (rst_n_i === 1'b1) cmp(echo_read_enable_n_o, echo_prev, "echo off edge");
    end
  end

  // hang guard
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end

  // main sequence
  initial begin
    t_straps();
    do_reset(1'b0, 1'b0, 1'b0);
    t_regs();
    t_std();
    do_reset(1'b0, 1'b1, 1'b1);
    t_async();
    do_reset(1'b1, 1'b0, 1'b0);
    t_fall_through_mode();
    summarize();
  end
endmodule : fifo_flag_echo_expansion_tb
`default_nettype wire
